// ===== shared/mem_decode_pkg.sv
// constants for the memory decoder, remap and boot strap logic
package mem_decode_pkg;
    // ****************************************
    // address map
    // ****************************************
    localparam logic [31:0] ext_base = 32'h0040_0000;
    localparam logic [31:0] ext_limit = 32'hffc0_0000;
    localparam logic [31:0] vector_top = 32'h0000_0020;
    localparam int ext_bank_count = 8;
    localparam int bank_sel_lo = 20; // 1 Mbyte bank granule
    // ****************************************
    // reset timing
    // ****************************************
    localparam int fetch_delay_cycles = 80;
    localparam int strap_window_cycles = 10;
    localparam logic [6:0] fetch_cnt_init = 7'h00;
    // ****************************************
    // target regions and sizes
    // ****************************************
    typedef enum logic [2:0] {
        tgt_none, tgt_boot, tgt_sram, tgt_ext, tgt_periph
    } target_t;
    localparam logic [1:0] size_byte = 2'h0;
    localparam logic [1:0] size_half = 2'h1;
    localparam logic [1:0] size_word = 2'h2;
    localparam logic boot_width_8 = 1'b1;
endpackage

// ===== design/memory_decode_remap_boot.sv
// memory decoder with boot straps, remap and abort generation
`timescale 1ns/1ps

// ****************************************
// top module
// ****************************************
module memory_decode_remap_boot #(
    parameter int bank_size_log2 = 20,
    parameter int banks_used = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wdog_reset_i,
    input wire logic boot_width_strap_i,
    input wire logic tristate_strap_n_i,
    input wire logic remap_wr_i,
    input wire logic remap_cmd_bit_i,
    input wire logic clk_out_as_io_i,
    input wire logic req_i,
    input wire logic write_i,
    input wire logic fetch_i,
    input wire logic [1:0] size_i,
    input wire logic [31:0] addr_i,
    input wire logic [banks_used-1:0] bank_defined_i,
    output logic sys_reset_n_o,
    output logic fetch_enable_o,
    output logic boot_width_8_o,
    output logic tristate_mode_o,
    output logic remapped_o,
    output logic clk_out_sel_o,
    output logic sel_sram_o,
    output logic sel_boot_o,
    output logic sel_ext_o,
    output logic sel_periph_o,
    output logic [banks_used-1:0] chip_select_n_o,
    output logic [3:0] byte_en_o,
    output logic abort_o
);
    // ****************************************
    // reset release and watchdog merge
    // ****************************************
    logic pin_rst_s1_q;
    logic pin_rst_s2_q;
    logic sys_rst_n_q;
    // timeline after the pin rises, counted in clock edges:
    //   edge 1  first sync flop goes high, straps are captured next
    //   edge 2  second sync flop high, pin reset no longer active
    //   edge 3  internal reset released to the rest of the block
    //   edge 4  sys_reset_n_o follows, fetch counter starts
    //   edge 80 fetch_enable_o rises
    // the watchdog path skips the strap capture entirely, so the
    // boot width and tristate modes of the last pin reset survive
    // it; a watchdog pulse that overlaps a pin reset is ignored
    // because the pin already holds everything in reset

    // pin reset acts at once, release waits two clock edges
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_rst_s1_q <= 1'b0;
            pin_rst_s2_q <= 1'b0;
        end else begin
            pin_rst_s1_q <= 1'b1;
            pin_rst_s2_q <= pin_rst_s1_q;
        end
    end

    // watchdog reset only counts while the pin is released
    wire pin_active = !pin_rst_s2_q;
    wire wdog_active = wdog_reset_i && !pin_active;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_rst_n_q <= 1'b0;
        end else begin
            sys_rst_n_q <= !(pin_active || wdog_active);
        end
    end

    // ****************************************
    // strap sampling
    // ****************************************
    // three-flop synchronisers; the first flop feeds only the second
    logic [2:0] bw_sync_q;
    logic [2:0] tri_sync_q;
    logic [3:0] tri_low_cnt_q;
    logic bw_last_q;
    logic boot_width_q;
    logic tristate_q;

    // no reset here on purpose: the straps only matter while the pin
    // holds reset, so these flops must keep sampling then; an async
    // clear would pin them at fixed values for the whole window
    always_ff @(posedge clk_i) begin
        bw_sync_q <= {bw_sync_q[1:0], boot_width_strap_i};
        tri_sync_q <= {tri_sync_q[1:0], tristate_strap_n_i};
    end

    wire bw_stable = bw_sync_q[1] == bw_sync_q[2];
    wire tri_low = !tri_sync_q[1] && !tri_sync_q[2];
    // release edge of the pin reset: straps are captured here only
    wire pin_release = pin_rst_s2_q && !pin_rst_s1_q ? 1'b0 :
        (pin_rst_s1_q && !pin_rst_s2_q);
    wire [3:0] tri_cnt_max = 4'(mem_decode_pkg::strap_window_cycles);

    // the tristate counter counts synchronised low cycles and stops
    // at the window length; any high cycle starts it again, so only
    // a strap held low over the whole final window selects tristate.
    // the release edge still counts, as it sees the pin as active,
    // but the capture happens on that same edge and misses that count.
    // limitation: the counter has no reset, straps must be steady
    // sampling runs only while the pin holds reset; the straps keep
    // their levels across a watchdog reset because it never gets here
    always_ff @(posedge clk_i) begin
        if (pin_active) begin
            if (bw_stable) begin
                bw_last_q <= bw_sync_q[2];
            end
            if (!tri_low) begin
                tri_low_cnt_q <= 4'h0;
            end else if (tri_low_cnt_q != tri_cnt_max) begin
                tri_low_cnt_q <= tri_low_cnt_q + 4'h1;
            end
        end
    end

    // latched modes: loaded at pin release only, never by watchdog
    always_ff @(posedge clk_i) begin
        if (pin_release) begin
            boot_width_q <= bw_last_q;
            tristate_q <= (tri_low_cnt_q == tri_cnt_max);
        end
    end

    // ****************************************
    // first fetch delay
    // ****************************************
    // edge 3 releases the internal reset, the counter runs from edge 4
    // to its end value, then two flops (enable and output) follow;
    // subtracting five lands the output on the 80th edge after release
    localparam logic [6:0] fetch_cnt_end =
        7'(mem_decode_pkg::fetch_delay_cycles - 5);
    logic [6:0] fetch_cnt_q;
    logic fetch_en_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fetch_cnt_q <= mem_decode_pkg::fetch_cnt_init;
            fetch_en_q <= 1'b0;
        end else if (!sys_rst_n_q) begin
            fetch_cnt_q <= mem_decode_pkg::fetch_cnt_init;
            fetch_en_q <= 1'b0;
        end else if (fetch_cnt_q != fetch_cnt_end) begin
            fetch_cnt_q <= fetch_cnt_q + 7'h01;
        end else begin
            fetch_en_q <= 1'b1;
        end
    end

    // ****************************************
    // remap control
    // ****************************************
    logic remap_q;
    // one-way: a zero write is ignored, only reset clears it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            remap_q <= 1'b0;
        end else if (!sys_rst_n_q) begin
            remap_q <= 1'b0;
        end else if (remap_wr_i && remap_cmd_bit_i) begin
            remap_q <= 1'b1;
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    // three regions by plain compares on the full address:
    //   below the external base    internal memories
    //   at or above the top limit  internal peripherals
    //   everything between         external bus unit banks
    // the compares are cheap next to a full table and keep the
    // region edges in the package; bank decode below only looks
    // at the external window, so the low and high regions never
    // reach a chip select except cs0 for boot before remap
    wire in_low = addr_i < mem_decode_pkg::ext_base;
    wire in_high = addr_i >= mem_decode_pkg::ext_limit;
    wire in_ext = !in_low && !in_high;
    // before remap the whole low region shows the boot memory
    wire go_boot = in_low && !remap_q;
    wire go_sram = in_low && remap_q;
    wire [7:0] bank_idx = addr_i[bank_size_log2 +: 8];
    wire [7:0] bank_rel = bank_idx - 8'(mem_decode_pkg::ext_base
        >> bank_size_log2);
    // cs0 follows the external window and boot before remap; cs1..7 serve the external window only
    wire bank_ok = (bank_rel < 8'(banks_used)) &&
        bank_defined_i[bank_rel[2:0]];
    wire ext_abort = req_i && in_ext && !bank_ok;

    // little-endian lane enables for byte, half and word; lane 0 is
    // the lowest address byte. misaligned halves and words are not
    // split: addr_i[0] is ignored for halves and addr_i[1:0] for words, which is
    // what the aligned-only external bus expects anyway
    logic [3:0] lanes;
    always_comb begin
        case (size_i)
            mem_decode_pkg::size_byte: lanes = 4'h1 << addr_i[1:0];
            mem_decode_pkg::size_half: lanes = addr_i[1] ? 4'hc : 4'h3;
            mem_decode_pkg::size_word: lanes = 4'hf;
            default: lanes = 4'hf;
        endcase
    end

    // per-bank chip selects, active low
    logic [banks_used-1:0] cs_n_d;
    generate
        for (genvar b = 0; b < banks_used; b++) begin : g_cs
            // boot memory rides on bank zero before remap
            assign cs_n_d[b] = !(req_i && ((in_ext && bank_ok &&
                bank_rel[2:0] == 3'(b)) || (b == 0 && go_boot)));
        end
    endgenerate

    // ****************************************
    // registered outputs
    // ****************************************
    // every select, lane and abort answers one cycle after the
    // request edge and stands for exactly one cycle per request.
    // chip selects are forced high while the internal reset is
    // held or tristate mode was strapped, so no external device
    // sees a strobe then; the abort is also masked in reset
    // registered so every output comes from a flop; SRAM still one cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_sram_o <= 1'b0;
            sel_boot_o <= 1'b0;
            sel_ext_o <= 1'b0;
            sel_periph_o <= 1'b0;
            chip_select_n_o <= '1;
            byte_en_o <= 4'h0;
            abort_o <= 1'b0;
        end else begin
            sel_sram_o <= req_i && go_sram;
            sel_boot_o <= req_i && go_boot;
            sel_ext_o <= req_i && in_ext && bank_ok;
            sel_periph_o <= req_i && in_high;
            chip_select_n_o <= (sys_rst_n_q && !tristate_q) ?
                cs_n_d : '1;
            // peripherals are word only: lanes forced to a word
            byte_en_o <= !req_i ? 4'h0 : (in_high ? 4'hf : lanes);
            abort_o <= ext_abort && sys_rst_n_q;
        end
    end

    // status outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_reset_n_o <= 1'b0;
            fetch_enable_o <= 1'b0;
            boot_width_8_o <= mem_decode_pkg::boot_width_8;
            tristate_mode_o <= 1'b0;
            remapped_o <= 1'b0;
            clk_out_sel_o <= 1'b1;
        end else begin
            sys_reset_n_o <= sys_rst_n_q;
            // tristate only silences pin drivers; the core still runs
            fetch_enable_o <= fetch_en_q;
            boot_width_8_o <= boot_width_q;
            tristate_mode_o <= tristate_q;
            remapped_o <= remap_q;
            // reset hands the pin back to the clock copy
            clk_out_sel_o <= !sys_rst_n_q || !clk_out_as_io_i;
        end
    end

    // bank timing is held in the external bus unit
    // this decoder passes it the bank select and lane enables only.
    // the bank size parameter covers the range from eight small to
    // four large banks; with larger banks the unused upper selects
    // simply stay high because bank_defined_i marks them undefined,
    // and any access there aborts like any other hole in the
    // external window
endmodule // memory_decode_remap_boot

// ===== tb/memory_decode_remap_boot_properties.sv
// checker for decode, remap, strap and clock-out behaviour
`timescale 1ns/1ps
module mem_decode_props #(
    parameter int bank_size_log2 = 20,
    parameter int banks_used = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wdog_reset_i,
    input wire logic remap_wr_i,
    input wire logic remap_cmd_bit_i,
    input wire logic clk_out_as_io_i,
    input wire logic req_i,
    input wire logic [1:0] size_i,
    input wire logic [31:0] addr_i,
    input wire logic [banks_used-1:0] bank_defined_i,
    input wire logic sys_reset_n_o,
    input wire logic tristate_mode_o,
    input wire logic remapped_o,
    input wire logic clk_out_sel_o,
    input wire logic sel_sram_o,
    input wire logic sel_boot_o,
    input wire logic sel_ext_o,
    input wire logic sel_periph_o,
    input wire logic [banks_used-1:0] chip_select_n_o,
    input wire logic [3:0] byte_en_o,
    input wire logic abort_o
);
    // ****************************************
    // helpers
    // ****************************************
    localparam logic [31:0] eb = mem_decode_pkg::ext_base;
    localparam logic [31:0] el = mem_decode_pkg::ext_limit;
    wire logic in_ext = addr_i >= eb && addr_i < el;
    wire logic [31:0] bidx = (addr_i >> bank_size_log2) -
        (eb >> bank_size_log2);
    // out-of-range index never reached: the first term wins
    wire logic undef = bidx >= 32'(banks_used) || !bank_defined_i[bidx[7:0]];
    // decode rules only hold once running and not in tristate
    wire logic ok = sys_reset_n_o && !wdog_reset_i && !tristate_mode_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_ext_select: assert property (req_i && in_ext && ok |=>
        sel_ext_o == !$past(undef)) else $error("ext select wrong");
    a_abort_undef: assert property (req_i && in_ext && undef && ok
        |=> abort_o) else $error("no abort on undefined ext address");
    a_abort_def: assert property (req_i && in_ext && !undef && ok
        |=> !abort_o) else $error("abort on defined ext address");
    a_periph_clean: assert property (req_i && addr_i >= el && ok |=>
        sel_periph_o && !abort_o && byte_en_o == 4'hf) else $error("bad periph");
    a_boot_first: assert property (req_i && addr_i < eb && ok
        && !remapped_o && !remap_wr_i && !$past(remap_wr_i)
        |=> sel_boot_o) else $error("no boot");
    a_sram_after: assert property (req_i && addr_i < eb && ok
        && remapped_o |=> sel_sram_o && !abort_o)
        else $error("sram not at zero");
    a_remap_set: assert property ((remap_wr_i && remap_cmd_bit_i && ok
        ##1 ok [*2]) |-> remapped_o) else $error("remap not taken");
    a_remap_kept: assert property (remapped_o && ok ##1 ok |-> remapped_o)
        else $error("remap lost without reset");
    a_tristate_cs: assert property (tristate_mode_o |-> &chip_select_n_o)
        else $error("chip select driven in tristate");
    a_clk_copy: assert property (!clk_out_as_io_i [*3] |-> clk_out_sel_o)
        else $error("clock copy missing");
    a_byte_lane: assert property (req_i && in_ext && ok
        && size_i == 2'h0
        |=> byte_en_o == 4'h1 << $past(addr_i[1:0])) else $error("bad lane");
endmodule // mem_decode_props

// ===== tb/core_model.sv
// processor core model issuing single-cycle bus requests
`timescale 1ns/1ps
module core_model (
    input wire logic clk_i,
    output logic req_o,
    output logic write_o,
    output logic fetch_o,
    output logic [1:0] size_o,
    output logic [31:0] addr_o
);
    // idle bus at time zero
    initial begin
        req_o = 1'b0;
        write_o = 1'b0;
        fetch_o = 1'b0;
        size_o = 2'h2;
        addr_o = 32'h0;
    end
    // one request cycle; the released address is inverted so a stale
    // value is never mistaken for a held one
    task automatic access(input logic [31:0] a, input logic [1:0] sz,
        input logic wr);
        @(negedge clk_i);
        req_o = 1'b1;
        write_o = wr;
        fetch_o = a < 32'h20 && !wr;
        size_o = sz;
        addr_o = a;
        @(negedge clk_i);
        req_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule // core_model

// ===== tb/memory_decode_remap_boot_tb.sv
// self-checking bench for the memory decoder and reset logic
`timescale 1ns/1ps
module memory_decode_remap_boot_tb;
    logic clk_i = 0, reset_n_i = 0, wdog_reset_i = 0;
    logic boot_width_strap_i = 1, tristate_strap_n_i = 1;
    logic remap_wr_i = 0, remap_cmd_bit_i = 0, clk_out_as_io_i = 0;
    logic req_i, write_i, fetch_i;
    logic [1:0] size_i;
    logic [31:0] addr_i;
    logic [7:0] bank_defined_i = 8'hff;
    logic sys_reset_n_o, fetch_enable_o, boot_width_8_o, tristate_mode_o;
    logic remapped_o, clk_out_sel_o, sel_sram_o, sel_boot_o, sel_ext_o;
    logic sel_periph_o, abort_o;
    logic [7:0] chip_select_n_o;
    logic [3:0] byte_en_o;
    int bad_count = 0, compares = 0;
    // 50 MHz master clock
    always #10 clk_i = ~clk_i;
    memory_decode_remap_boot u_dut (.*);
    core_model u_core (.clk_i(clk_i), .req_o(req_i), .write_o(write_i),
        .fetch_o(fetch_i), .size_o(size_i), .addr_o(addr_i));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // pin reset with straps; clock runs all through the low phase
    task automatic pin_reset(input logic b, input logic t, input logic w);
        int n;
        reset_n_i = 0;
        wdog_reset_i = w;
        boot_width_strap_i = b;
        tristate_strap_n_i = t;
        repeat (12) @(negedge clk_i);
        chk({sys_reset_n_o, clk_out_sel_o}, 2'h1);
        reset_n_i = 1;
        wdog_reset_i = 0;
        n = 0;
        while (!fetch_enable_o && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk(n, 80);
        chk({boot_width_8_o, tristate_mode_o}, {b, !t});
        chk({sys_reset_n_o, remapped_o}, 2'h2);
    endtask
    // boot decode, lanes and peripherals before remap
    task automatic t_boot;
        u_core.access(32'h0, 2'h2, 0);
        chk({sel_boot_o, chip_select_n_o}, 9'h1fe);
        u_core.access(32'h0040_0003, 2'h0, 1);
        chk({sel_ext_o, byte_en_o}, 5'h18);
        u_core.access(32'hffc0_0006, 2'h1, 0);
        chk({sel_periph_o, abort_o, byte_en_o}, 6'h2f);
    endtask
    // zero write ignored, one write remaps, then upper banks
    task automatic t_remap;
        remap_wr_i = 1;
        remap_cmd_bit_i = 0;
        @(negedge clk_i);
        remap_wr_i = 0;
        repeat (2) @(negedge clk_i);
        chk(remapped_o, 0);
        remap_wr_i = 1;
        remap_cmd_bit_i = 1;
        @(negedge clk_i);
        remap_wr_i = 0;
        @(negedge clk_i);
        chk(remapped_o, 1);
        u_core.access(32'h0000_0010, 2'h2, 1);
        chk({sel_sram_o, sel_boot_o, abort_o}, 3'h4);
        u_core.access(32'h0000_0002, 2'h1, 0);
        chk({sel_sram_o, byte_en_o}, 5'h1c);
        u_core.access(32'h00b0_0000, 2'h2, 0);
        chk({abort_o, chip_select_n_o}, 9'h07f);
        bank_defined_i = 8'h7f;
        u_core.access(32'h00b0_0000, 2'h2, 0);
        chk(abort_o, 1);
        u_core.access(32'h00c0_0000, 2'h2, 0);
        chk(abort_o, 1);
        bank_defined_i = 8'hff;
    endtask
    // watchdog reset clears remap but keeps the latched straps
    task automatic t_wdog;
        wdog_reset_i = 1;
        boot_width_strap_i = 0;
        repeat (12) @(negedge clk_i);
        chk(sys_reset_n_o, 0);
        wdog_reset_i = 0;
        repeat (100) @(negedge clk_i);
        chk({remapped_o, boot_width_8_o, fetch_enable_o}, 3'h3);
    endtask
    // main sequence
    initial begin
        repeat (6) @(negedge clk_i);
        pin_reset(1, 1, 0);
        t_boot;
        t_remap;
        clk_out_as_io_i = 1;
        repeat (3) @(negedge clk_i);
        chk(clk_out_sel_o, 0);
        clk_out_as_io_i = 0;
        t_wdog;
        pin_reset(0, 1, 1);
        pin_reset(1, 0, 0);
        u_core.access(32'h0040_0000, 2'h2, 0);
        chk(chip_select_n_o, 8'hff);
        finish_test;
    end
    // watchdog: the sequence needs under a thousand cycles
    initial begin
        #400000;
        bad_count++;
        finish_test;
    end
endmodule // memory_decode_remap_boot_tb
bind memory_decode_remap_boot mem_decode_props #(
    .bank_size_log2(bank_size_log2), .banks_used(banks_used)) u_props (.*);
